/* core/adc_evt_pkg.sv */
// Purpose: shared constants and types for the converter event and interrupt control block
// Assumes: one 50 MHz clock, word-aligned AHB-Lite register access
// Notes: printed offsets are register indexes; byte address is four times the index
package adc_evt_pkg;

    // ****************************************
    // register indexes and byte addresses
    // ****************************************
    localparam logic [7:0] IDX_INPUT_CTRL = 8'h10;
    localparam logic [7:0] IDX_EVENT_CONTROL = 8'h14;
    localparam logic [7:0] IDX_IRQ_ENABLE_CLEAR = 8'h16;
    localparam logic [7:0] IDX_IRQ_ENABLE_SET = 8'h17;
    localparam logic [7:0] IDX_IRQ_FLAGS = 8'h18;
    localparam logic [7:0] IDX_STATUS = 8'h19;
    localparam logic [7:0] IDX_RESULT = 8'h1a;
    localparam logic [9:0] ADDR_INPUT_CTRL = {IDX_INPUT_CTRL, 2'b00};
    localparam logic [9:0] ADDR_EVENT_CONTROL = {IDX_EVENT_CONTROL, 2'b00};
    localparam logic [9:0] ADDR_IRQ_ENABLE_CLEAR = {IDX_IRQ_ENABLE_CLEAR, 2'b00};
    localparam logic [9:0] ADDR_IRQ_ENABLE_SET = {IDX_IRQ_ENABLE_SET, 2'b00};
    localparam logic [9:0] ADDR_IRQ_FLAGS = {IDX_IRQ_FLAGS, 2'b00};
    localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
    localparam logic [9:0] ADDR_RESULT = {IDX_RESULT, 2'b00};

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int BIT_START_EVENT_IN = 0;
    localparam int BIT_FLUSH_EVENT_IN = 1;
    localparam int BIT_RESULT_EVENT_OUT = 4;
    localparam int BIT_WINDOW_EVENT_OUT = 5;
    localparam int BIT_RESULT_AVAIL = 0;
    localparam int BIT_OVERRUN = 1;
    localparam int BIT_WINDOW_MATCH = 2;
    localparam int BIT_SYNC_DONE = 3;
    localparam int BIT_SYNC_IN_PROGRESS = 7;
    localparam logic [3:0] RST_IRQ = 4'h0;
    localparam logic [15:0] RST_RESULT = 16'h0000;
    localparam logic [4:0] RST_MUX = 5'h00;

    // ****************************************
    // positive input selector codes
    // ****************************************
    localparam logic [4:0] MUX_LAST_PIN = 5'h13;
    localparam logic [4:0] MUX_TEMP = 5'h18;
    localparam logic [4:0] MUX_BANDGAP = 5'h19;
    localparam logic [4:0] MUX_CORE_QUARTER = 5'h1a;
    localparam logic [4:0] MUX_IO_QUARTER = 5'h1b;
    localparam logic [4:0] MUX_DAC = 5'h1c;

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic window_event_out_en;
        logic result_event_out_en;
        logic flush_event_in_en;
        logic start_event_in_en;
    } event_control_s;

    typedef struct packed {
        logic pin;
        logic [4:0] pin_index;
        logic temp;
        logic bandgap;
        logic core_supply_quarter;
        logic io_supply_quarter;
        logic dac;
        logic reserved;
    } input_route_s;

endpackage

/* core/adc_event_interrupt_ctrl.sv */
// Purpose: event routing, interrupt flags and input selector decode of the converter
// Assumes: converter core signals arrive on clk as one-cycle pulses or levels
// Notes: AHB-Lite slave, zero wait states, always OKAY
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps

// Operation
// - codes 0x18 temp, 0x1A core, 0x1C dac
// - 0x19 bandgap, 0x1B io, 0x00-0x13 pins
// - window enable gates window match output event
// - result enable gates result ready output event
// - flush enable: event flushes then converts
// - start enable: event starts a conversion
// - enable-clear ones clear enables and requests
// - enable-set ones set; both read enables
// - request when flag and enable both set
// - sync done on busy fall, not enable/reset
// - window flag set cycle after match
// - result read clears window and result flags
// - overrun when result overwritten before read
// - result flag set when result available
// - write one clears flag; reset zero
// - status bit 7 shows sync busy
// - result register holds sixteen bits
module adc_event_interrupt_ctrl
    import adc_evt_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic event_in,
    output logic start_conversion,
    output logic flush_conversion,
    input wire logic result_valid,
    input wire logic [15:0] result_data,
    input wire logic window_match,
    output logic result_event_out,
    output logic window_event_out,
    input wire logic sync_in_progress,
    input wire logic sync_end_by_enable_or_reset,
    output input_route_s input_route,
    output logic irq
);

    // ****************************************
    // state
    // ****************************************
    logic wr_pend_q;
    logic [9:0] wr_addr_q;
    event_control_s evctl_q;
    logic [3:0] irq_en_q;
    logic [3:0] irq_flags_q;
    logic [4:0] positive_input_select_q;
    logic [15:0] result_q;
    logic result_unread_q;
    logic sync_busy_q;
    logic [3:0] flag_set;
    logic [3:0] flag_clr;
    logic rd_take;
    logic [9:0] rd_addr;
    logic result_read;
    logic wr_flags;
    logic [31:0] rd_value;

    // ****************************************
    // bus slave
    // ****************************************
    // never stalls, so a data phase always ends in one cycle
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign rd_take = hsel & hready & htrans[1] & ~hwrite;
    assign rd_addr = haddr[9:0];
    assign result_read = rd_take & (rd_addr == ADDR_RESULT);
    assign wr_flags = wr_pend_q & (wr_addr_q == ADDR_IRQ_FLAGS);

    // capture the write address phase; data follows next cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 10'h000;
        end else begin
            wr_pend_q <= hsel & hready & htrans[1] & hwrite;
            wr_addr_q <= haddr[9:0];
        end
    end

    // read mux; unmapped and misaligned words read as zero
    always_comb begin
        rd_value = 32'h0000_0000;
        if (rd_addr == ADDR_INPUT_CTRL) begin
            rd_value[4:0] = positive_input_select_q;
        end else if (rd_addr == ADDR_EVENT_CONTROL) begin
            rd_value[BIT_WINDOW_EVENT_OUT] = evctl_q.window_event_out_en;
            rd_value[BIT_RESULT_EVENT_OUT] = evctl_q.result_event_out_en;
            rd_value[BIT_FLUSH_EVENT_IN] = evctl_q.flush_event_in_en;
            rd_value[BIT_START_EVENT_IN] = evctl_q.start_event_in_en;
        end else if (rd_addr == ADDR_IRQ_ENABLE_CLEAR || rd_addr == ADDR_IRQ_ENABLE_SET) begin
            rd_value[3:0] = irq_en_q;
        end else if (rd_addr == ADDR_IRQ_FLAGS) begin
            rd_value[3:0] = irq_flags_q;
        end else if (rd_addr == ADDR_STATUS) begin
            rd_value[BIT_SYNC_IN_PROGRESS] = sync_busy_q;
        end else if (rd_addr == ADDR_RESULT) begin
            rd_value[15:0] = result_q;
        end
    end

    // read data registered at the address phase, shown in the data phase
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_take) begin
            hrdata <= rd_value;
        end
    end

    // ****************************************
    // configuration registers
    // ****************************************
    // event control and input selector
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            evctl_q <= '0;
            positive_input_select_q <= RST_MUX;
        end else if (wr_pend_q) begin
            if (wr_addr_q == ADDR_EVENT_CONTROL) begin
                evctl_q.window_event_out_en <= hwdata[BIT_WINDOW_EVENT_OUT];
                evctl_q.result_event_out_en <= hwdata[BIT_RESULT_EVENT_OUT];
                evctl_q.flush_event_in_en <= hwdata[BIT_FLUSH_EVENT_IN];
                evctl_q.start_event_in_en <= hwdata[BIT_START_EVENT_IN];
            end else if (wr_addr_q == ADDR_INPUT_CTRL) begin
                positive_input_select_q <= hwdata[4:0];
            end
        end
    end

    // interrupt enables: clear is checked first; a word hits only one of the two
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_en_q <= RST_IRQ;
        end else if (wr_pend_q) begin
            if (wr_addr_q == ADDR_IRQ_ENABLE_CLEAR) begin
                irq_en_q <= irq_en_q & ~hwdata[3:0];
            end else if (wr_addr_q == ADDR_IRQ_ENABLE_SET) begin
                irq_en_q <= irq_en_q | hwdata[3:0];
            end
        end
    end

    // ****************************************
    // result register and flags
    // ****************************************
    // result capture; read marks it consumed
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            result_q <= RST_RESULT;
            result_unread_q <= 1'b0;
        end else begin
            if (result_valid) begin
                result_q <= result_data;
                result_unread_q <= 1'b1;
            end else if (result_read) begin
                result_unread_q <= 1'b0;
            end
        end
    end

    // sync busy tracker for edge detection
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_busy_q <= 1'b0;
        end else begin
            sync_busy_q <= sync_in_progress;
        end
    end

    // flag sources; a set in the same cycle as a clear is kept
    always_comb begin
        flag_set = 4'h0;
        flag_clr = 4'h0;
        flag_set[BIT_SYNC_DONE] = sync_busy_q & ~sync_in_progress & ~sync_end_by_enable_or_reset;
        flag_set[BIT_WINDOW_MATCH] = window_match;
        flag_set[BIT_OVERRUN] = result_valid & result_unread_q & ~result_read;
        flag_set[BIT_RESULT_AVAIL] = result_valid;
        if (wr_flags) begin
            flag_clr = hwdata[3:0];
        end
        if (result_read) begin
            flag_clr[BIT_WINDOW_MATCH] = 1'b1;
            flag_clr[BIT_RESULT_AVAIL] = 1'b1;
        end
    end

    // sticky flags, write one to clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_flags_q <= RST_IRQ;
        end else begin
            irq_flags_q <= (irq_flags_q & ~flag_clr) | flag_set;
        end
    end

    // ****************************************
    // interrupt output
    // ****************************************
    // combinational so an enable clear withdraws the request at once
    assign irq = |(irq_flags_q & irq_en_q);

    // ****************************************
    // events
    // ****************************************
    // one-cycle event pulses, registered
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            start_conversion <= 1'b0;
            flush_conversion <= 1'b0;
            result_event_out <= 1'b0;
            window_event_out <= 1'b0;
        end else begin
            start_conversion <= event_in & evctl_q.start_event_in_en;
            flush_conversion <= event_in & evctl_q.flush_event_in_en;
            result_event_out <= result_valid & evctl_q.result_event_out_en;
            window_event_out <= window_match & evctl_q.window_event_out_en;
        end
    end

    // ****************************************
    // positive input selector decode
    // ****************************************
    // reserved codes route nothing and raise the reserved marker
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            input_route <= '0;
        end else begin
            input_route <= '0;
            input_route.pin_index <= positive_input_select_q;
            if (positive_input_select_q <= MUX_LAST_PIN) begin
                input_route.pin <= 1'b1;
            end else if (positive_input_select_q == MUX_TEMP) begin
                input_route.temp <= 1'b1;
            end else if (positive_input_select_q == MUX_BANDGAP) begin
                input_route.bandgap <= 1'b1;
            end else if (positive_input_select_q == MUX_CORE_QUARTER) begin
                input_route.core_supply_quarter <= 1'b1;
            end else if (positive_input_select_q == MUX_IO_QUARTER) begin
                input_route.io_supply_quarter <= 1'b1;
            end else if (positive_input_select_q == MUX_DAC) begin
                input_route.dac <= 1'b1;
            end else begin
                input_route.reserved <= 1'b1;
            end
        end
    end

endmodule

/* test/adc_evt_checker.sv */
// Purpose: port assertions for the converter event and interrupt block
// Assumes: one clock domain, sys_rst active high
// Notes: only ports are visible, so enable state is not known here
`timescale 1ns/1ps
module adc_evt_checker
    import adc_evt_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic event_in,
    input wire logic start_conversion,
    input wire logic flush_conversion,
    input wire logic result_valid,
    input wire logic window_match,
    input wire logic result_event_out,
    input wire logic window_event_out,
    input wire logic sync_in_progress,
    input wire input_route_s input_route,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ****************************************
    // event and interrupt relations
    // ****************************************
    sequence ev_taken;
        event_in ##1 (start_conversion || flush_conversion);
    endsequence
    sequence wr_taken;
        hsel && htrans[1] && hwrite;
    endsequence
    // a rise needs a cause: result, match, a write or a sync fall two or three edges back
    property irq_rise_p;
        $rose(irq) |-> $past(result_valid) || $past(window_match) || $past(hsel && htrans[1] && hwrite, 2)
            || $past(sync_in_progress, 2) || $past(sync_in_progress, 3);
    endproperty
    start_cause_a: assert property (start_conversion |-> $past(event_in))
        else $error("start without event");
    flush_cause_a: assert property (flush_conversion |-> $past(event_in))
        else $error("flush without event");
    res_evt_cause_a: assert property (result_event_out |-> $past(result_valid))
        else $error("result event without result");
    win_evt_cause_a: assert property (window_event_out |-> $past(window_match))
        else $error("window event without match");
    route_onehot_a: assert property ($onehot0({input_route.pin, input_route[5:0]}))
        else $error("input route not one hot");
    route_pin_a: assert property (input_route.pin |-> input_route.pin_index <= 5'h13)
        else $error("pin index beyond last pin");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    irq_cause_a: assert property (irq_rise_p)
        else $error("interrupt rose without cause");
    cover property (ev_taken);
    cover property (wr_taken);
endmodule

bind adc_event_interrupt_ctrl adc_evt_checker u_adc_evt_checker (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp), .event_in(event_in),
    .start_conversion(start_conversion), .flush_conversion(flush_conversion), .result_valid(result_valid),
    .window_match(window_match), .result_event_out(result_event_out), .window_event_out(window_event_out),
    .sync_in_progress(sync_in_progress), .input_route(input_route), .irq(irq));

/* test/conv_model.sv */
// Purpose: behavioural converter core answering start and flush requests
// Assumes: one result per trigger after lat idle cycles
// Notes: data line toggles when no result stands on it
`timescale 1ns/1ps
module conv_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic start_conversion,
    input wire logic flush_conversion,
    input wire logic [3:0] lat,
    output logic result_valid,
    output logic [15:0] result_data,
    output logic window_match
);
    logic busy_q;
    logic [3:0] cnt_q;
    logic [15:0] num_q;
    // ****************************************
    // conversion timing
    // ****************************************
    // a new trigger restarts the count, so a flush aborts the running conversion
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_q <= 1'h0;
            cnt_q <= 4'h0;
            num_q <= 16'h0;
            result_valid <= 1'h0;
            result_data <= 16'h0;
            window_match <= 1'h0;
        end else begin
            result_valid <= 1'h0;
            window_match <= 1'h0;
            result_data <= ~result_data;
            if (start_conversion || flush_conversion) begin
                busy_q <= 1'h1;
                cnt_q <= lat;
            end else if (busy_q && cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end else if (busy_q) begin
                busy_q <= 1'h0;
                result_valid <= 1'h1;
                result_data <= 16'ha5a0 + num_q;
                window_match <= num_q[0];
                num_q <= num_q + 16'h1;
            end
        end
    end
endmodule

/* test/tb.sv */
// Purpose: self-checking bench for the converter event and interrupt block
// Assumes: zero-wait AHB-Lite slave, 50 MHz clock
// Notes: reads and output events are compared against queued notes
`timescale 1ns/1ps
module tb
    import adc_evt_pkg::*;
;
    logic clk = '0, sys_rst = '1, hsel = '0, hwrite = '0, event_in = '0, rd_take = '0;
    logic sync_busy = '0, sync_why = '0;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = 3'h2;
    logic [3:0] lat = 4'h1;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic hreadyout, hresp, start_conversion, flush_conversion, result_valid, window_match;
    logic result_event_out, window_event_out, irq;
    logic [15:0] result_data;
    input_route_s input_route, ex, got;
    logic [7:0] ev_q = '0;
    logic [31:0] rq[$];
    logic [3:0] eq[$];
    int errors = 0, comparisons = 0, cycles = 0, nres = 0;
    adc_event_interrupt_ctrl u_adc_event_interrupt_ctrl (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .event_in(event_in),
        .start_conversion(start_conversion), .flush_conversion(flush_conversion), .result_valid(result_valid),
        .result_data(result_data), .window_match(window_match), .result_event_out(result_event_out),
        .window_event_out(window_event_out), .sync_in_progress(sync_busy),
        .sync_end_by_enable_or_reset(sync_why), .input_route(input_route), .irq(irq));
    conv_model u_conv_model (.clk(clk), .sys_rst(sys_rst), .start_conversion(start_conversion),
        .flush_conversion(flush_conversion), .lat(lat), .result_valid(result_valid), .result_data(result_data),
        .window_match(window_match));
    // ****************************************
    // shared tasks
    // ****************************************
    always #10 clk = ~clk;
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, g, e);
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // address phase held until hready, then data phase held until hready again
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= {22'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        rd_take <= !w;
        do @(posedge clk); while (hreadyout !== 1'h1);
        chk(hresp, 32'h0, "response");
        rd_take <= 1'h0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        rq.push_back(e);
        bus(1'h0, a, 32'h0);
    endtask
    // one incoming event; notes the trigger pulse and, later, the result and window events it leads to
    task automatic fire();
        event_in <= 1'h1;
        if (ev_q[1:0] != 2'h0) eq.push_back({ev_q[0], ev_q[1], 2'h0});
        @(posedge clk);
        event_in <= 1'h0;
        if (ev_q[1:0] != 2'h0 && (ev_q[4] || (ev_q[5] && nres % 2 == 1))) eq.push_back({2'h0, ev_q[4], ev_q[5] && nres % 2 == 1});
        if (ev_q[1:0] != 2'h0) nres++;
        repeat (12) @(posedge clk);
    endtask
    task automatic sync_fall(input logic why);
        sync_busy <= 1'h1;
        repeat (2) @(posedge clk);
        rd(ADDR_STATUS, 32'h80);
        sync_busy <= 1'h0;
        sync_why <= why;
        @(posedge clk);
        sync_why <= 1'h0;
        repeat (3) @(posedge clk);
    endtask
    // ****************************************
    // watchers
    // ****************************************
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (rd_take) chk(hrdata, rq.size() ? rq.pop_front() : 32'hdead, "read");
        if (start_conversion | flush_conversion | result_event_out | window_event_out) begin
            chk({start_conversion, flush_conversion, result_event_out, window_event_out}, eq.size() ? eq.pop_front() : 4'h0, "event");
        end
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        void'($urandom(47101));
        repeat (2) @(posedge clk);
        sys_rst <= 1'h0;
        rd(ADDR_EVENT_CONTROL, 32'h0);
        rd(ADDR_IRQ_ENABLE_SET, 32'h0);
        rd(ADDR_IRQ_FLAGS, 32'h0);
        rd(10'h3fc, 32'h0);
        for (int i = 0; i < 12; i++) begin
            ev_q = (i < 4) ? 8'(i) | 8'h30 : 8'($urandom) & 8'h33;
            lat <= 4'($urandom_range(7));
            bus(1'h1, ADDR_EVENT_CONTROL, {24'h0, ev_q});
            rd(ADDR_EVENT_CONTROL, {24'h0, ev_q});
            fire();
        end
        bus(1'h1, ADDR_IRQ_FLAGS, 32'h0);
        rd(ADDR_IRQ_FLAGS, 32'h7);
        chk(irq, 1'h0, "irq masked");
        bus(1'h1, ADDR_IRQ_ENABLE_SET, 32'hf);
        bus(1'h1, ADDR_IRQ_ENABLE_SET, 32'h0);
        rd(ADDR_IRQ_ENABLE_CLEAR, 32'hf);
        chk(irq, 1'h1, "irq raised");
        rd(ADDR_RESULT, 32'ha5a0 + nres - 1);
        rd(ADDR_IRQ_FLAGS, 32'h2);
        bus(1'h1, ADDR_IRQ_ENABLE_CLEAR, 32'h5);
        rd(ADDR_IRQ_ENABLE_SET, 32'ha);
        bus(1'h1, ADDR_IRQ_FLAGS, 32'h2);
        rd(ADDR_IRQ_FLAGS, 32'h0);
        ev_q = 8'h01;
        bus(1'h1, ADDR_EVENT_CONTROL, 32'h1);
        fire();
        chk(irq, 1'h0, "irq withdrawn");
        rd(ADDR_IRQ_FLAGS, {29'h0, nres % 2 == 0, 2'h1});
        bus(1'h1, ADDR_IRQ_FLAGS, 32'hf);
        sync_fall(1'h1);
        rd(ADDR_IRQ_FLAGS, 32'h0);
        sync_fall(1'h0);
        rd(ADDR_IRQ_FLAGS, 32'h8);
        chk(irq, 1'h1, "irq on sync");
        for (int c = 0; c < 32; c++) begin
            bus(1'h1, ADDR_INPUT_CTRL, 32'(c));
            repeat (2) @(posedge clk);
            ex = '0;
            ex.pin = (c < 20);
            ex.pin_index = ex.pin ? 5'(c) : 5'h0;
            ex.temp = (c == 24);
            ex.bandgap = (c == 25);
            ex.core_supply_quarter = (c == 26);
            ex.io_supply_quarter = (c == 27);
            ex.dac = (c == 28);
            ex.reserved = !ex.pin && (c < 24 || c > 28);
            got = input_route;
            if (!got.pin) got.pin_index = 5'h0;
            chk({20'h0, got}, {20'h0, ex}, "route");
        end
        chk(eq.size() + rq.size(), 32'h0, "notes left");
        give_verdict();
    end
endmodule
